/* include/arm_pkg.sv */
// Constants for the alarm relay and mode controller: register map, field layout, timing.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
package arm_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned DELAY_MAX_S     = 60;
    localparam int unsigned BASELINE_MIN    = 5;
    localparam int unsigned ACCL_LEARN_H    = 24;
    localparam int unsigned ACCL_WINDOW_H   = 1;
    localparam int unsigned SEC_PER_MIN     = 60;
    localparam int unsigned SEC_PER_HOUR    = 3600;
    localparam int unsigned TICK_CYC        = CLK_HZ;
    localparam int unsigned BASELINE_SEC    = BASELINE_MIN * SEC_PER_MIN;
    localparam int unsigned ACCL_LEARN_SEC  = ACCL_LEARN_H * SEC_PER_HOUR;
    localparam int unsigned ACCL_WINDOW_SEC = ACCL_WINDOW_H * SEC_PER_HOUR;
    // ==========================================================
    // Thresholds in units of 0.00005 %obs/m.
    localparam logic [19:0] THR_ALERT_RST   = 20'h0_0318;
    localparam logic [19:0] THR_FIRE1_RST   = 20'h0_4074;
    localparam logic [19:0] THR_FIRE2_RST   = 20'h0_80E8;
    localparam logic [19:0] THR_MIN         = 20'h0_0013;
    localparam logic [19:0] THR_MAX         = 20'h6_1A80;
    // ==========================================================
    // Log capacities and trend limits.
    localparam logic [15:0] EVT_LOG_MAX     = 16'h4650;
    localparam logic [15:0] MSG_LOG_MAX     = 16'h012C;
    localparam logic [7:0]  TREND_MIN       = 8'h01;
    localparam logic [7:0]  TREND_MAX_MIN   = 8'h3C;
    localparam logic [7:0]  TREND_MAX_HOUR  = 8'h18;
    // ==========================================================
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_CMD     = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_PART    = 8'h0C;
    localparam logic [7:0] REG_THR0    = 8'h10;
    localparam logic [7:0] REG_DLY0    = 8'h20;
    localparam logic [7:0] REG_HI0     = 8'h30;
    localparam logic [7:0] REG_ACC0    = 8'h40;
    localparam logic [7:0] REG_CFGSTG  = 8'h50;
    localparam logic [7:0] REG_CFGCMT  = 8'h54;
    localparam logic [7:0] REG_LOGCNT  = 8'h58;
    localparam logic [7:0] REG_MSGCNT  = 8'h5C;
    localparam logic [7:0] REG_TREND   = 8'h60;
    // ==========================================================
    // CTRL bits.
    localparam int unsigned CTL_LATCH0  = 0;
    localparam int unsigned CTL_ALMTONE = 3;
    localparam int unsigned CTL_FLTTONE = 4;
    localparam int unsigned CTL_DNW     = 5;
    localparam int unsigned CTL_ACCL    = 6;
    // CMD bits (write one to request).
    localparam int unsigned CMD_RESET   = 0;
    localparam int unsigned CMD_TEST    = 1;
    localparam int unsigned CMD_ISOL    = 2;
    localparam int unsigned CMD_BASE    = 3;
    localparam int unsigned CMD_EVTLOG  = 4;
    localparam int unsigned CMD_MSGLOG  = 5;
    localparam int unsigned CMD_CFGFLT  = 6;
    typedef enum logic [2:0] {
        ARM_NORMAL,
        ARM_TEST,
        ARM_ISOLATE,
        ARM_DISABLE
    } arm_mode_e;
endpackage

/* logic/arm_ctrl.sv */
// Alarm relay and operating mode controller of an aspirating smoke detector.
// Assumes a 20 MHz clock, APB master for configuration, and synchronous keypad and monitor inputs.
// Summary of operation
// - Three alarm levels each light an indicator and drive a relay at or above threshold.
// - Each level selects latching or non-latching relay behaviour.
// - Each level waits its own delay, zero to sixty seconds, before asserting.
// - Default thresholds alert 0.0396, fire1 0.825, fire2 1.65; range clamped.
// - Alarm and fault sounder tones independently pulsed or continuous.
// - A staged threshold applies only on a commit that finds it in range.
// - Interrupted upload restarts on old config with one-shot config fault.
// - Any fault in normal mode lights fault indicator, code and fault relay.
// - Test mode lights all bars and alarms, relays follow programmed delays.
// - Test mode exits only through reset or the disable key.
// - Reset drops all relays, returns to normal except from disable, standing conditions reassert.
// - Baseline reset discards baselines and runs a five-minute period.
// - Isolate only from normal; isolate relay on, alarm and fault relays frozen off.
// - Disable only locally; isolate relay, disable fault, fan off, displays blank.
// - Disable persists until explicit exit; communication stays active.
// - Day, night and weekend threshold sets selected by time and weekday.
// - Acclimate monitors 24 hours, then steps one unit an hour from insensitive bound to the other limit; hour peak zeroed before compare.
// - Equal acclimate limits give a static level; current levels readable.
// - Event log counts up to 18000 entries.
// - Trend interval 1 to 60 minutes or 1 to 24 hours.
// - Message log holds up to 300 messages.
// - Monitor open sets monitor fault and fault relay; short performs reset.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module arm_ctrl
    import arm_pkg::*;
#(
    parameter int unsigned TICK       = TICK_CYC,
    parameter int unsigned BASE_SEC   = BASELINE_SEC,
    parameter int unsigned LEARN_SEC  = ACCL_LEARN_SEC,
    parameter int unsigned WIN_SEC    = ACCL_WINDOW_SEC
) (
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [19:0] particulate_i,
    input  wire logic        fault_i,
    input  wire logic [3:0]  fault_code_i,
    input  wire logic        cfg_upload_lost_i,
    input  wire logic        key_reset_i,
    input  wire logic        key_test_i,
    input  wire logic        key_isolate_i,
    input  wire logic        key_disable_i,
    input  wire logic        key_enable_i,
    input  wire logic        key_baseline_i,
    input  wire logic        night_i,
    input  wire logic        weekend_i,
    input  wire logic        mon_open_i,
    input  wire logic        mon_short_i,
    output logic      [2:0]  alarm_relay_o,
    output logic      [2:0]  alarm_led_o,
    output logic      [9:0]  bar_led_o,
    output logic             fault_relay_o,
    output logic             fault_led_o,
    output logic      [3:0]  fault_code_o,
    output logic             mon_fault_led_o,
    output logic             isolate_relay_o,
    output logic             isolate_led_o,
    output logic             disable_fault_o,
    output logic             fan_on_o,
    output logic             airflow_disp_o,
    output logic             baseline_busy_o,
    output logic             baseline_clear_o,
    output logic             sounder_o
);
    // ==========================================================
    // Registers
    arm_mode_e   mode_ff;
    logic [31:0] ctrl_ff;
    logic [19:0] thr_ff  [3][3];
    logic [19:0] hi_ff   [3];
    logic [19:0] acc_ff  [3];
    logic [19:0] stg_ff;
    logic [5:0]  dly_ff  [3];
    logic [19:0] peak_ff [3];
    logic [5:0]  dcnt_ff [3];
    logic [2:0]  alarm_ff;
    logic [24:0] tick_ff;
    logic        sec_ff;
    logic [16:0] learn_ff;
    logic [12:0] win_ff;
    logic [8:0]  base_ff;
    logic        cfgflt_ff;
    logic [15:0] evt_ff;
    logic [15:0] msg_ff;
    logic [8:0]  trend_ff;
    logic [23:0] pulse_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic [2:0]  relay_ff;
    logic [2:0]  aled_ff;
    logic [9:0]  bar_ff;
    logic        frel_ff;
    logic        fled_ff;
    logic [3:0]  fcode_ff;
    logic        mled_ff;
    logic        isol_ff;
    logic        dis_ff;
    logic        base_clr_ff;
    logic        snd_ff;
    function automatic logic [19:0] clamp_thr(input logic [19:0] v);
        return (v < THR_MIN) ? THR_MIN : ((v > THR_MAX) ? THR_MAX : v);
    endfunction
    // ==========================================================
    // APB decode
    wire        acc      = psel_i & penable_i & ~pready_ff;
    wire        wr       = acc & pwrite_i;
    wire [1:0]  dl       = paddr_i[3:2];
    wire        wr_ctrl  = wr && paddr_i == REG_CTRL;
    wire        wr_cmd   = wr && paddr_i == REG_CMD;
    // The direct threshold window reaches the day set only; night and weekend go through the commit.
    wire        wr_thr   = wr && paddr_i >= REG_THR0 && paddr_i < REG_DLY0 && dl != 2'd3;
    wire        wr_dly   = wr && paddr_i >= REG_DLY0 && paddr_i < REG_HI0 && dl != 2'd3;
    wire        wr_hi    = wr && paddr_i >= REG_HI0 && paddr_i < REG_ACC0 && dl != 2'd3;
    wire        wr_stg   = wr && paddr_i == REG_CFGSTG;
    wire        wr_cmt   = wr && paddr_i == REG_CFGCMT;
    wire        wr_trend = wr && paddr_i == REG_TREND;
    wire        trend_ok = pwdata_i[8] ? (pwdata_i[7:0] >= TREND_MIN && pwdata_i[7:0] <= TREND_MAX_HOUR)
                                       : (pwdata_i[7:0] >= TREND_MIN && pwdata_i[7:0] <= TREND_MAX_MIN);
    wire        cmt_ok   = wr_cmt && pwdata_i[1:0] != 2'b11 && stg_ff >= THR_MIN && stg_ff <= THR_MAX;
    // ==========================================================
    // Requests and mode priority
    // keypad, monitor short or remote reset
    wire        do_reset = key_reset_i | mon_short_i | (wr_cmd & pwdata_i[CMD_RESET]);
    wire        req_test = key_test_i | (wr_cmd & pwdata_i[CMD_TEST]);
    wire        req_isol = key_isolate_i | (wr_cmd & pwdata_i[CMD_ISOL]);
    wire        is_dis   = mode_ff == ARM_DISABLE;
    wire        is_norm  = mode_ff == ARM_NORMAL;
    arm_mode_e  nxt_mode;
    assign nxt_mode = is_dis ? (key_enable_i ? ARM_NORMAL : ARM_DISABLE)
                    : key_disable_i ? ARM_DISABLE
                    : do_reset ? ARM_NORMAL
                    : (is_norm & req_isol) ? ARM_ISOLATE
                    : (is_norm & req_test) ? ARM_TEST
                    : mode_ff;
    // ==========================================================
    // Thresholds in use
    wire [1:0]  tset     = ctrl_ff[CTL_DNW] ? (weekend_i ? 2'd2 : (night_i ? 2'd1 : 2'd0)) : 2'd0;
    wire        learned  = learn_ff == 17'(LEARN_SEC);
    logic [2:0] over;
    for (genvar g = 0; g < 3; g++) begin : g_lvl
        wire [19:0] thr = (ctrl_ff[CTL_ACCL] && learned) ? acc_ff[g] : thr_ff[tset][g];
        assign over[g] = (ctrl_ff[CTL_ACCL] && !learned) ? 1'b0 : particulate_i >= thr;
    end
    wire        test_m   = mode_ff == ARM_TEST;
    wire        reld     = is_norm | test_m;
    wire        any_flt  = fault_i | cfgflt_ff | mon_open_i;
    // ==========================================================
    // Sequential
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_ff   <= ARM_NORMAL;
            ctrl_ff   <= '0;
            stg_ff    <= '0;
            tick_ff   <= '0;
            sec_ff    <= 1'b0;
            learn_ff  <= '0;
            win_ff    <= '0;
            base_ff   <= '0;
            cfgflt_ff <= 1'b0;
            evt_ff    <= '0;
            msg_ff    <= '0;
            trend_ff  <= 9'h001;
            pulse_ff  <= '0;
            alarm_ff  <= '0;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                for (int s = 0; s < 3; s++) begin
                    thr_ff[s][i] <= (i == 0) ? THR_ALERT_RST : ((i == 1) ? THR_FIRE1_RST : THR_FIRE2_RST);
                end
                hi_ff[i]   <= (i == 0) ? THR_ALERT_RST : ((i == 1) ? THR_FIRE1_RST : THR_FIRE2_RST);
                acc_ff[i]  <= (i == 0) ? THR_ALERT_RST : ((i == 1) ? THR_FIRE1_RST : THR_FIRE2_RST);
                peak_ff[i] <= '0;
                dly_ff[i]  <= '0;
                dcnt_ff[i] <= '0;
            end
        end else begin
            mode_ff   <= nxt_mode;
            pready_ff <= acc;
            tick_ff   <= (tick_ff == 25'(TICK - 1)) ? '0 : tick_ff + 25'd1;
            sec_ff    <= tick_ff == 25'(TICK - 1);
            pulse_ff  <= pulse_ff + 24'd1;
            if (wr_ctrl) ctrl_ff <= pwdata_i;
            if (wr_stg) stg_ff <= pwdata_i[19:0];
            if (wr_trend && trend_ok) trend_ff <= pwdata_i[8:0];
            if (wr_thr) thr_ff[0][dl] <= clamp_thr(pwdata_i[19:0]);
            if (wr_dly) dly_ff[dl] <= (pwdata_i[5:0] > 6'(DELAY_MAX_S)) ? 6'(DELAY_MAX_S) : pwdata_i[5:0];
            if (wr_hi) hi_ff[dl] <= clamp_thr(pwdata_i[19:0]);
            if (cmt_ok) thr_ff[pwdata_i[3:2]][pwdata_i[1:0]] <= stg_ff;
            if (cfg_upload_lost_i) cfgflt_ff <= 1'b1;
            else if (do_reset || (wr_cmd && pwdata_i[CMD_CFGFLT])) cfgflt_ff <= 1'b0;
            if (key_baseline_i || (wr_cmd && pwdata_i[CMD_BASE])) base_ff <= 9'(BASE_SEC);
            else if (sec_ff && base_ff != '0) base_ff <= base_ff - 9'd1;
            if (wr_cmd && pwdata_i[CMD_EVTLOG] && evt_ff < EVT_LOG_MAX) evt_ff <= evt_ff + 16'd1;
            if (wr_cmd && pwdata_i[CMD_MSGLOG] && msg_ff < MSG_LOG_MAX) msg_ff <= msg_ff + 16'd1;
            if (!ctrl_ff[CTL_ACCL]) begin
                learn_ff <= '0;
                win_ff   <= '0;
            end else if (sec_ff && !learned) begin
                learn_ff <= learn_ff + 17'd1;
            end else if (sec_ff) begin
                win_ff <= (win_ff == 13'(WIN_SEC - 1)) ? '0 : win_ff + 13'd1;
            end
            for (int i = 0; i < 3; i++) begin
                if (!learned || win_ff == 13'(WIN_SEC - 1)) begin
                    peak_ff[i] <= '0;
                end else if (particulate_i > peak_ff[i]) begin
                    peak_ff[i] <= particulate_i;
                end
                if (!learned) begin
                    acc_ff[i] <= thr_ff[0][i];
                end else if (sec_ff && win_ff == 13'(WIN_SEC - 1)) begin
                    acc_ff[i] <= (peak_ff[i] >= acc_ff[i]) ? thr_ff[0][i]
                               : ((acc_ff[i] > hi_ff[i]) ? acc_ff[i] - 20'd1 : hi_ff[i]);
                end
                if (do_reset || !(over[i] || test_m)) begin
                    dcnt_ff[i] <= '0;
                end else if (sec_ff && dcnt_ff[i] != dly_ff[i]) begin
                    dcnt_ff[i] <= dcnt_ff[i] + 6'd1;
                end
                if (do_reset) begin
                    alarm_ff[i] <= 1'b0;
                end else if ((over[i] || test_m) && dcnt_ff[i] == dly_ff[i]) begin
                    alarm_ff[i] <= 1'b1;
                end else if (!over[i] && !test_m && !ctrl_ff[CTL_LATCH0 + i]) begin
                    alarm_ff[i] <= 1'b0;
                end
            end
            if (acc) begin
                if (paddr_i == REG_CTRL) prdata_ff <= ctrl_ff;
                else if (paddr_i == REG_STATUS) prdata_ff <= {16'h0, learned, base_ff != '0, cfgflt_ff,
                                                              mon_open_i, alarm_ff, any_flt, 5'h0, 3'(mode_ff)};
                else if (paddr_i == REG_PART) prdata_ff <= {12'h0, particulate_i};
                else if (paddr_i >= REG_THR0 && paddr_i < REG_DLY0 && dl != 2'd3)
                    prdata_ff <= {12'h0, thr_ff[0][dl]};
                else if (paddr_i >= REG_DLY0 && paddr_i < REG_HI0 && dl != 2'd3)
                    prdata_ff <= {26'h0, dly_ff[dl]};
                else if (paddr_i >= REG_HI0 && paddr_i < REG_ACC0 && dl != 2'd3)
                    prdata_ff <= {12'h0, hi_ff[dl]};
                else if (paddr_i >= REG_ACC0 && paddr_i < REG_CFGSTG && dl != 2'd3)
                    prdata_ff <= {12'h0, acc_ff[dl]};
                else if (paddr_i == REG_CFGSTG) prdata_ff <= {12'h0, stg_ff};
                else if (paddr_i == REG_LOGCNT) prdata_ff <= {16'h0, evt_ff};
                else if (paddr_i == REG_MSGCNT) prdata_ff <= {16'h0, msg_ff};
                else if (paddr_i == REG_TREND) prdata_ff <= {23'h0, trend_ff};
                else prdata_ff <= '0;
            end
        end
    end
    // ==========================================================
    // Outputs
    // relays frozen
    wire [2:0]  nxt_relay  = (do_reset || !reld) ? 3'b000 : alarm_ff;
    wire        nxt_frel   = !do_reset && is_norm && any_flt;
    wire        tone_sel   = (|alarm_ff) ? ctrl_ff[CTL_ALMTONE] : ctrl_ff[CTL_FLTTONE];
    wire        nxt_snd    = (!is_dis && ((|alarm_ff) || any_flt)) && (tone_sel ? 1'b1 : pulse_ff[23]);
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            relay_ff    <= '0;
            aled_ff     <= '0;
            bar_ff      <= '0;
            frel_ff     <= 1'b0;
            fled_ff     <= 1'b0;
            fcode_ff    <= '0;
            mled_ff     <= 1'b0;
            isol_ff     <= 1'b0;
            dis_ff      <= 1'b0;
            base_clr_ff <= 1'b0;
            snd_ff      <= 1'b0;
        end else begin
            relay_ff    <= nxt_relay;
            aled_ff     <= is_dis ? 3'b000 : (test_m ? 3'b111 : alarm_ff);
            bar_ff      <= is_dis ? 10'h000 : (test_m ? 10'h3FF : {10{1'b0}} | 10'(particulate_i[19:10]));
            frel_ff     <= nxt_frel;
            fled_ff     <= any_flt | is_dis;
            fcode_ff    <= cfgflt_ff ? 4'hE : (mon_open_i ? 4'hD : fault_code_i);
            mled_ff     <= mon_open_i;
            isol_ff     <= mode_ff == ARM_ISOLATE || is_dis;
            dis_ff      <= is_dis;
            base_clr_ff <= key_baseline_i || (wr_cmd && pwdata_i[CMD_BASE]);
            snd_ff      <= nxt_snd;
        end
    end
    assign prdata_o         = prdata_ff;
    assign pready_o         = pready_ff;
    assign pslverr_o        = 1'b0;
    assign alarm_relay_o    = relay_ff;
    assign alarm_led_o      = aled_ff;
    assign bar_led_o        = bar_ff;
    assign fault_relay_o    = frel_ff;
    assign fault_led_o      = fled_ff;
    assign fault_code_o     = fcode_ff;
    assign mon_fault_led_o  = mled_ff;
    assign isolate_relay_o  = isol_ff;
    assign isolate_led_o    = isol_ff;
    assign disable_fault_o  = dis_ff;
    assign fan_on_o         = ~dis_ff;
    assign airflow_disp_o   = ~dis_ff;
    assign baseline_busy_o  = |base_ff;
    assign baseline_clear_o = base_clr_ff;
    assign sounder_o        = snd_ff;
endmodule
`default_nettype wire

/* dv/arm_ctrl_assertions.sv */
// Port checker for the alarm relay and mode controller.
// Bound to arm_ctrl by the bench; tick parameters are the short bench values.
`timescale 1ns/100ps
`default_nettype none
module arm_ctrl_chk (
    input wire logic       clock_i, arst_n_i, psel_i, penable_i, pready_o, key_reset_i,
    input wire logic       fault_i, mon_open_i, mon_short_i, fault_relay_o, fault_led_o, mon_fault_led_o,
    input wire logic       isolate_relay_o, isolate_led_o, disable_fault_o, fan_on_o, airflow_disp_o,
    input wire logic       baseline_busy_o, baseline_clear_o,
    input wire logic [2:0] alarm_relay_o, alarm_led_o,
    input wire logic [9:0] bar_led_o
);
    // ==========================================================
    // Relay, display and bus timing checks.
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    rdy_answer_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no bus answer");
    rdy_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    iso_frozen_a: assert property (isolate_relay_o [*2] |-> alarm_relay_o == 3'b000 && !fault_relay_o)
        else $error("relay active while isolated");
    iso_led_a: assert property (isolate_relay_o && !disable_fault_o |-> isolate_led_o)
        else $error("isolate status dark");
    dis_blank_a: assert property (disable_fault_o [*2] |-> !fan_on_o && bar_led_o == 10'h000
        && alarm_led_o == 3'b000 && !airflow_disp_o && isolate_relay_o) else $error("disable not blanked");
    // A reset in the window legally drops the relay for a cycle, so it is excluded.
    fault_set_a: assert property ((fault_i && !isolate_relay_o && !key_reset_i && !mon_short_i) [*4]
        |-> fault_relay_o && fault_led_o) else $error("fault not shown");
    mon_fault_a: assert property ((mon_open_i && !isolate_relay_o && !key_reset_i) [*4]
        |-> fault_relay_o && mon_fault_led_o) else $error("monitor open not shown");
    short_reset_a: assert property ($rose(mon_short_i) |-> ##[1:2] alarm_relay_o == 3'b000)
        else $error("short did not reset");
    base_run_a: assert property ($rose(baseline_busy_o) |-> baseline_busy_o [*8])
        else $error("baseline period cut short");
    base_end_a: assert property ($rose(baseline_busy_o) |-> ##[18:32] !baseline_busy_o)
        else $error("baseline period length");
    base_clear_a: assert property (baseline_clear_o |-> ##[0:1] baseline_busy_o)
        else $error("baseline clear without period");
endmodule
`default_nettype wire

/* dv/arm_panel_model.sv */
// Fire panel input side: remembers which relay contacts have closed.
// Assumes relay outputs are active high; clear_i forgets the history.
`timescale 1ns/100ps
`default_nettype none
module arm_panel_model (
    input  wire logic       clock_i,
    input  wire logic       clear_i,
    input  wire logic [2:0] alarm_relay_i,
    input  wire logic       fault_relay_i,
    input  wire logic       isolate_relay_i,
    output logic      [4:0] seen_o
);
    // A contact closure of even one cycle is kept, as a panel input would latch it.
    always @(posedge clock_i) begin
        seen_o <= clear_i ? 5'h00 : seen_o | {isolate_relay_i, fault_relay_i, alarm_relay_i};
    end
endmodule
`default_nettype wire

/* dv/arm_ctrl_bench.sv */
// Self-checking bench for the alarm relay and mode controller.
// Assumes short tick parameters; keys are {upload lost, test, baseline, enable, disable, isolate, reset}.
`timescale 1ns/100ps
`default_nettype none
module arm_ctrl_bench import arm_pkg::*;;
    logic        clock_i, arst_n_i, psel_i, penable_i, pwrite_i, fault_i, mon_open_i, mon_short_i, clr;
    logic        pready_o, fault_relay_o, fault_led_o, mon_fault_led_o, isolate_relay_o, isolate_led_o;
    logic        disable_fault_o, fan_on_o, airflow_disp_o, baseline_busy_o, baseline_clear_o;
    logic [2:0]  alarm_relay_o, alarm_led_o;
    logic [3:0]  fault_code_o;
    logic [4:0]  seen;
    logic [6:0]  keys;
    logic [7:0]  paddr_i;
    logic [9:0]  bar_led_o;
    logic [19:0] particulate_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    int          err_count, total_checks, cyc_cnt;
    arm_ctrl #(.TICK(10), .BASE_SEC(3), .LEARN_SEC(4), .WIN_SEC(3)) arm_ctrl_i (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(),
        .particulate_i(particulate_i), .fault_i(fault_i), .fault_code_i(4'h3), .cfg_upload_lost_i(keys[6]),
        .key_reset_i(keys[0]), .key_test_i(keys[5]), .key_isolate_i(keys[1]), .key_disable_i(keys[2]),
        .key_enable_i(keys[3]), .key_baseline_i(keys[4]), .night_i(1'b0), .weekend_i(1'b0),
        .mon_open_i(mon_open_i), .mon_short_i(mon_short_i), .alarm_relay_o(alarm_relay_o),
        .alarm_led_o(alarm_led_o), .bar_led_o(bar_led_o), .fault_relay_o(fault_relay_o), .fault_led_o(fault_led_o),
        .fault_code_o(fault_code_o), .mon_fault_led_o(mon_fault_led_o), .isolate_relay_o(isolate_relay_o),
        .isolate_led_o(isolate_led_o), .disable_fault_o(disable_fault_o), .fan_on_o(fan_on_o),
        .airflow_disp_o(airflow_disp_o), .baseline_busy_o(baseline_busy_o), .baseline_clear_o(baseline_clear_o),
        .sounder_o());
    arm_panel_model arm_panel_model_i (.clock_i(clock_i), .clear_i(clr), .alarm_relay_i(alarm_relay_o),
        .fault_relay_i(fault_relay_o), .isolate_relay_i(isolate_relay_o), .seen_o(seen));
    // ==========================================================
    // Shared tasks.
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic pulse(input logic [6:0] k);
        keys <= k;
        cyc(1);
        keys <= '0;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d; penable_i <= 1'b0;
        cyc(1);
        penable_i <= 1'b1;
        do cyc(1); while (pready_o !== 1'b1);
        r = prdata_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
        cyc(1);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t seen %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_regs;
        apb(0, REG_THR0, 0, rd); chk(rd, {12'h000, THR_ALERT_RST});
        apb(0, 8'h18, 0, rd); chk(rd, {12'h000, THR_FIRE2_RST});
        apb(1, REG_THR0, 32'h0000_0001, rd); apb(0, REG_THR0, 0, rd); chk(rd, {12'h000, THR_MIN});
        apb(1, REG_THR0, 32'h0000_0100, rd); apb(0, 8'hFC, 0, rd); chk(rd, 32'h0000_0000);
        $display("registers done");
    endtask
    task automatic t_alarm;
        apb(1, REG_DLY0, 32'h0000_0002, rd); particulate_i <= 20'h0_0400; cyc(5); chk(alarm_relay_o, 0);
        cyc(30); chk(alarm_relay_o, 3'b001); chk(alarm_led_o, 3'b001);
        particulate_i <= 20'h0_0000; cyc(5); chk(alarm_relay_o, 0);
        apb(1, REG_DLY0, 0, rd); apb(1, REG_CTRL, 32'h0000_0001, rd); particulate_i <= 20'h0_0400; cyc(5);
        particulate_i <= 20'h0_0000; cyc(5); chk(alarm_relay_o, 3'b001);
        mon_short_i <= 1'b1; cyc(3); chk(alarm_relay_o, 0); mon_short_i <= 1'b0;
        apb(1, REG_CTRL, 0, rd); $display("alarm done");
    endtask
    task automatic t_isolate;
        particulate_i <= 20'h0_0400; fault_i <= 1'b1; cyc(6); pulse(5'b00010); cyc(3); clr <= 1'b1; cyc(1);
        clr <= 1'b0; cyc(10); chk(seen, 5'b10000); chk(alarm_led_o, 3'b001); chk(isolate_led_o, 1);
        pulse(5'b00001); cyc(6); chk(isolate_relay_o, 0); chk(alarm_relay_o, 3'b001);
        chk(fault_relay_o, 1); chk(fault_code_o, 4'h3);
        particulate_i <= 20'h0_0000; fault_i <= 1'b0; pulse(5'b00001); cyc(3);
        pulse(5'b00110); cyc(40); apb(0, REG_STATUS, 0, rd); chk(rd[2:0], 3'h3);
        chk(fan_on_o, 0); chk(disable_fault_o, 1);
        pulse(5'b01000); cyc(3); chk(fan_on_o, 1); chk(disable_fault_o, 0); $display("modes done");
    endtask
    task automatic t_test;
        apb(1, REG_CMD, 32'h0000_0002, rd); cyc(3); chk(bar_led_o, 10'h3FF); chk(alarm_led_o, 3'b111);
        pulse(5'b00010); cyc(3); apb(0, REG_STATUS, 0, rd); chk(rd[2:0], 3'h1);
        apb(1, REG_CMD, 32'h0000_0001, rd); cyc(3); apb(0, REG_STATUS, 0, rd); chk(rd[2:0], 3'h0);
        chk(alarm_relay_o, 0);
        pulse(7'h20); cyc(3); chk(alarm_led_o, 3'b111); pulse(7'h01); cyc(3);
        pulse(5'b10000); cyc(12); chk(baseline_busy_o, 1); cyc(30); chk(baseline_busy_o, 0);
        mon_open_i <= 1'b1; cyc(5); chk(fault_relay_o, 1); chk(fault_code_o, 4'hD);
        mon_open_i <= 1'b0; pulse(7'h40); cyc(3); chk(fault_code_o, 4'hE); chk(fault_relay_o, 1);
        pulse(5'b00001); cyc(4); chk(fault_relay_o, 0); $display("test done");
    endtask
    // ==========================================================
    // Clock, watchdog and main sequence.
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        arst_n_i = 0; psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = 0; pwdata_i = 0; keys = 0;
        fault_i = 0; mon_open_i = 0; mon_short_i = 0; particulate_i = 0; clr = 1;
        cyc(2);
        arst_n_i <= 1'b1;
        clr <= 1'b0;
        t_regs();
        t_alarm();
        t_isolate();
        t_test();
        final_report();
    end
endmodule
bind arm_ctrl arm_ctrl_chk arm_ctrl_chk_i (.*);
`default_nettype wire
